// ---- design/nfpbc_fifo.sv ----
// Parameterised first-in first-out buffer with valid and ready on both sides.
`timescale 1ns/1ps
module nfpbc_fifo #(
  parameter int W = 18,
  parameter int D = 8
) (
  input  wire logic         CLK,
  input  wire logic         RST,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int PW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [PW:0]  wr_reg;
  logic [PW:0]  rd_reg;
  logic         full;
  logic         empty;

  assign empty     = (wr_reg == rd_reg);
  assign full      = (wr_reg[PW-1:0] == rd_reg[PW-1:0]) && !empty;
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_reg[PW-1:0]];

  always_ff @(posedge CLK) begin
    if (in_valid && !full) begin
      mem[wr_reg[PW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (in_valid && !full) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_reg <= rd_reg + 1'b1;
      end
    end
  end
endmodule

// ---- design/nfpbc_host.sv ----
// Host controller that drives a NAND flash through its strobe pins.
//
// Function
// - With command latch high, present the command byte at write strobe rise.
// - Raise address latch for every address cycle; byte held at strobe rise.
// - Commands and addresses use the low eight lines; upper lines are zero.
// - Serial read cycle is at least 50 ns per byte or word.
// - Read and program take four address cycles, erase three row cycles.
`timescale 1ns/1ps
module nfpbc_host (
  input  wire logic                       CLK,
  input  wire logic                       RST,
  input  wire logic [nfpbc_pkg::AXI_AW-1:0] AWADDR,
  input  wire logic                       AWVALID,
  output logic                            AWREADY,
  input  wire logic [31:0]                WDATA,
  input  wire logic [3:0]                 WSTRB,
  input  wire logic                       WVALID,
  output logic                            WREADY,
  output logic [1:0]                      BRESP,
  output logic                            BVALID,
  input  wire logic                       BREADY,
  input  wire logic [nfpbc_pkg::AXI_AW-1:0] ARADDR,
  input  wire logic                       ARVALID,
  output logic                            ARREADY,
  output logic [31:0]                     RDATA,
  output logic [1:0]                      RRESP,
  output logic                            RVALID,
  input  wire logic                       RREADY,
  output logic                            CE_N,
  output logic                            CLE,
  output logic                            ALE,
  output logic                            WRITE_STROBE_N,
  output logic                            READ_STROBE_N,
  output logic                            WP_N,
  output logic                            LOCK_AUTOREAD_SELECT,
  input  wire logic [nfpbc_pkg::IO_W-1:0] IO_IN,
  output logic [nfpbc_pkg::IO_W-1:0]      IO_OUT,
  output logic                            IO_OE,
  input  wire logic                       READY_BUSY_N
);
  import nfpbc_pkg::*;
  nfpbc_state_t     state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [OP_W-1:0]  op_reg;
  logic [1:0]       ctrl_reg;
  logic [IO_W-1:0]  rdata_reg;
  logic             rvalid_flag_reg;
  logic             rb_reg;
  logic             ready_reg;
  logic             arready_reg;
  logic             bvalid_reg;
  logic             rvalid_reg;
  logic [1:0]       bresp_reg;
  logic [1:0]       rresp_reg;
  logic [31:0]      rdata_bus_reg;
  logic             aw_hs;
  logic             ar_hs;
  logic             fifo_in_valid;
  logic             fifo_in_ready;
  logic [OP_W-1:0]  fifo_out_data;
  logic             fifo_out_valid;
  logic             fifo_out_ready;
  logic             cmd_allowed;
  logic             rd_capture;
  logic [1:0]       head_kind;
  function automatic logic addr_mapped(input logic [AXI_AW-1:0] a);
    addr_mapped = (a == ADDR_CTRL) || (a == ADDR_OP) ||
                  (a == ADDR_RDATA) || (a == ADDR_STATUS);
  endfunction
  assign AWREADY        = ready_reg;
  assign WREADY         = ready_reg;
  assign BVALID         = bvalid_reg;
  assign BRESP          = bresp_reg;
  assign ARREADY        = arready_reg;
  assign RVALID         = rvalid_reg;
  assign RRESP          = rresp_reg;
  assign RDATA          = rdata_bus_reg;
  assign WP_N           = ctrl_reg[CTRL_WP_BIT];
  assign LOCK_AUTOREAD_SELECT = ctrl_reg[CTRL_LCK_BIT];
  assign aw_hs          = ready_reg && AWVALID && WVALID;
  assign ar_hs          = arready_reg && ARVALID;
  assign fifo_in_valid  = aw_hs && (AWADDR == ADDR_OP);
  assign head_kind      = fifo_out_data[OP_KIND_LSB +: 2];
  assign rd_capture     = (state_reg == ST_RLOW) && (cnt_reg == '0);
  // Only a busy flash holds back a new command; status and reset may pass.
  assign cmd_allowed = (head_kind != KIND_CMD) || rb_reg ||
                       (fifo_out_data[7:0] == CMD_STATUS) ||
                       (fifo_out_data[7:0] == CMD_RESET);
  assign fifo_out_ready = (state_reg == ST_IDLE) && cmd_allowed;
  nfpbc_fifo #(
    .W (OP_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .CLK       (CLK),
    .RST       (RST),
    .in_data   (WDATA[OP_W-1:0]),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready)
  );
  // A write to the operation queue waits while the queue is full.
  always_ff @(posedge CLK) begin
    if (RST) begin
      ready_reg  <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else begin
      ready_reg <= AWVALID && WVALID && !ready_reg && !bvalid_reg &&
                   ((AWADDR != ADDR_OP) || fifo_in_ready);
      if (aw_hs) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= addr_mapped(AWADDR) ? RESP_OKAY : RESP_SLVERR;
      end else if (BREADY) begin
        bvalid_reg <= 1'b0;
      end
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl_reg <= CTRL_RESET;
    end else if (aw_hs && (AWADDR == ADDR_CTRL) && WSTRB[0]) begin
      ctrl_reg <= WDATA[1:0];
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      arready_reg   <= 1'b0;
      rvalid_reg    <= 1'b0;
      rresp_reg     <= RESP_OKAY;
      rdata_bus_reg <= 32'h0;
    end else begin
      arready_reg <= ARVALID && !arready_reg && !rvalid_reg;
      if (ar_hs) begin
        rvalid_reg <= 1'b1;
        rresp_reg  <= addr_mapped(ARADDR) ? RESP_OKAY : RESP_SLVERR;
        case (ARADDR)
          ADDR_CTRL:   rdata_bus_reg <= {30'h0, ctrl_reg};
          ADDR_RDATA:  rdata_bus_reg <= {16'h0, rdata_reg};
          ADDR_STATUS: rdata_bus_reg <= {27'h0, rvalid_flag_reg,
                                         fifo_in_ready, !fifo_out_valid,
                                         rb_reg, (state_reg != ST_IDLE)};
          default:     rdata_bus_reg <= 32'h0;
        endcase
      end else if (RREADY) begin
        rvalid_reg <= 1'b0;
      end
    end
  end
  // Ready/busy is sampled once; it stays meaningful with the chip deselected.
  always_ff @(posedge CLK) begin
    if (RST) begin
      rb_reg <= 1'b1;
    end else begin
      rb_reg <= READY_BUSY_N;
    end
  end
  // A capture in the same cycle as a read of the data register wins.
  always_ff @(posedge CLK) begin
    if (RST) begin
      rdata_reg       <= '0;
      rvalid_flag_reg <= 1'b0;
    end else if (rd_capture) begin
      rdata_reg       <= IO_IN;
      rvalid_flag_reg <= 1'b1;
    end else if (ar_hs && (ARADDR == ADDR_RDATA)) begin
      rvalid_flag_reg <= 1'b0;
    end
  end
  // Chip select stays low over queued work so a busy operation is not cut.
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_reg      <= ST_IDLE;
      cnt_reg        <= '0;
      op_reg         <= '0;
      CE_N           <= 1'b1;
      CLE            <= 1'b0;
      ALE            <= 1'b0;
      WRITE_STROBE_N <= 1'b1;
      READ_STROBE_N  <= 1'b1;
      IO_OUT         <= '0;
      IO_OE          <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (fifo_out_valid && cmd_allowed) begin
            op_reg <= fifo_out_data;
            CE_N   <= 1'b0;
            CLE    <= (head_kind == KIND_CMD);
            ALE    <= (head_kind == KIND_ADDR);
            IO_OE  <= (head_kind != KIND_READ);
            IO_OUT <= (head_kind == KIND_WDATA) ?
                      fifo_out_data[IO_W-1:0] :
                      {8'h00, fifo_out_data[7:0]};
            state_reg <= ST_STROBE;
          end else if (!fifo_out_valid) begin
            CE_N <= 1'b1;
          end
        end
        ST_STROBE: begin
          if (op_reg[OP_KIND_LSB +: 2] == KIND_READ) begin
            READ_STROBE_N <= 1'b0;
            cnt_reg       <= CNT_W'(RACC_CYC - 1);
            state_reg     <= ST_RLOW;
          end else begin
            WRITE_STROBE_N <= 1'b0;
            cnt_reg        <= CNT_W'(WLOW_CYC - 1);
            state_reg      <= ST_WLOW;
          end
        end
        ST_WLOW: begin
          if (cnt_reg == '0) begin
            WRITE_STROBE_N <= 1'b1;
            cnt_reg        <= CNT_W'(WHIGH_CYC - 1);
            state_reg      <= ST_WHIGH;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        ST_WHIGH: begin
          if (cnt_reg == '0) begin
            CLE   <= 1'b0;
            ALE   <= 1'b0;
            IO_OE <= 1'b0;
            // Ready/busy falls only some time after a command is taken.
            cnt_reg   <= CNT_W'(WBUSY_CYC - 1);
            state_reg <= (op_reg[OP_KIND_LSB +: 2] == KIND_CMD) ?
                         ST_HOLD : ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        ST_RLOW: begin
          if (cnt_reg == '0) begin
            READ_STROBE_N <= 1'b1;
            cnt_reg       <= CNT_W'(RHIGH_CYC - 1);
            state_reg     <= ST_RHIGH;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        ST_RHIGH, ST_HOLD: begin
          if (cnt_reg == '0) begin
            state_reg <= ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
  AST_CMD_HELD: assert property (@(posedge CLK) disable iff (RST)
    $rose(WRITE_STROBE_N) && CLE |-> IO_OE && $stable(IO_OUT) && !ALE)
    else $error("Command byte not held at write strobe rise.");
  AST_ADDR_LATCH: assert property (@(posedge CLK) disable iff (RST)
    $fell(WRITE_STROBE_N) && ALE |->
    ALE[*3] ##1 ($rose(WRITE_STROBE_N) && ALE))
    else $error("Address latch dropped inside an address cycle.");
  AST_WE_PULSE: assert property (@(posedge CLK) disable iff (RST)
    $fell(WRITE_STROBE_N) |-> (!WRITE_STROBE_N)[*3] ##1 WRITE_STROBE_N[*2])
    else $error("Write strobe pulse has the wrong shape.");
  AST_READ_CAPTURE: assert property (@(posedge CLK) disable iff (RST)
    $fell(READ_STROBE_N) |-> ##2 rd_capture ##1 rvalid_flag_reg)
    else $error("Read data not captured after the access delay.");
  AST_NO_DRIVE_READ: assert property (@(posedge CLK) disable iff (RST)
    !READ_STROBE_N |-> !IO_OE && !CE_N)
    else $error("Host drives the port during a read cycle.");
  AST_UPPER_ZERO: assert property (@(posedge CLK) disable iff (RST)
    (CLE || ALE) && IO_OE |-> IO_OUT[15:8] == 8'h00)
    else $error("Upper lines used for a command or address.");
  AST_READ_CYCLE: assert property (@(posedge CLK) disable iff (RST)
    $fell(READ_STROBE_N) |-> ##3 READ_STROBE_N[*2])
    else $error("Read cycle shorter than the minimum.");
  AST_WAIT_READY: assert property (@(posedge CLK) disable iff (RST)
    $fell(WRITE_STROBE_N) && CLE && !$past(rb_reg, 2) |->
    IO_OUT[7:0] == CMD_STATUS || IO_OUT[7:0] == CMD_RESET)
    else $error("Command issued while the flash is busy.");
  AST_PROTECT_PINS: assert property (@(posedge CLK) disable iff (RST)
    aw_hs && AWADDR == ADDR_CTRL && WSTRB[0] |=>
    WP_N == $past(WDATA[0]) && LOCK_AUTOREAD_SELECT == $past(WDATA[1]))
    else $error("Protect pins do not follow the control write.");
endmodule

// ---- design/nfpbc_pkg.sv ----
// Shared constants and types of the NAND pin bus host controller.
package nfpbc_pkg;
  localparam int          CLK_MHZ      = 100;
  localparam int          AXI_AW       = 8;
  localparam int          IO_W         = 16;
  localparam int          OP_W         = 18;
  localparam int          FIFO_DEPTH   = 8;
  localparam logic [7:0]  ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_OP      = 8'h04;
  localparam logic [7:0]  ADDR_RDATA   = 8'h08;
  localparam logic [7:0]  ADDR_STATUS  = 8'h0c;
  localparam int          CTRL_WP_BIT  = 0;
  localparam int          CTRL_LCK_BIT = 1;
  localparam logic [1:0]  CTRL_RESET   = 2'h0;
  localparam int          OP_KIND_LSB  = 16;
  localparam logic [1:0]  KIND_CMD     = 2'h0;
  localparam logic [1:0]  KIND_ADDR    = 2'h1;
  localparam logic [1:0]  KIND_WDATA   = 2'h2;
  localparam logic [1:0]  KIND_READ    = 2'h3;
  localparam logic [7:0]  CMD_STATUS   = 8'h70;
  localparam logic [7:0]  CMD_RESET    = 8'hff;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  localparam int          T_WLOW_NS    = 25;
  localparam int          T_WHIGH_NS   = 15;
  localparam int          T_RACC_NS    = 30;
  localparam int          T_RHIGH_NS   = 15;
  localparam int          T_WBUSY_NS   = 100;
  localparam int          WLOW_CYC     = (T_WLOW_NS * CLK_MHZ + 999) / 1000;
  localparam int          WHIGH_CYC    = (T_WHIGH_NS * CLK_MHZ + 999) / 1000;
  localparam int          RACC_CYC     = (T_RACC_NS * CLK_MHZ + 999) / 1000;
  localparam int          RHIGH_CYC    = (T_RHIGH_NS * CLK_MHZ + 999) / 1000;
  localparam int          WBUSY_CYC    = (T_WBUSY_NS * CLK_MHZ + 999) / 1000;
  localparam int          CNT_W        = 4;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_STROBE = 3'b001,
    ST_WLOW   = 3'b010,
    ST_WHIGH  = 3'b011,
    ST_RLOW   = 3'b100,
    ST_RHIGH  = 3'b101,
    ST_HOLD   = 3'b110
  } nfpbc_state_t;
endpackage

// ---- verif/nfpbc_flash_model.sv ----
// Behavioural flash device seen from the host's pins.
`timescale 1ns/1ps
module nfpbc_flash_model #(
  parameter int PROG_NS  = 2000,
  parameter int ERASE_NS = 4000,
  parameter int FETCH_NS = 1000,
  parameter int ACC_NS   = 20
) (
  input  wire logic        ce_n,
  input  wire logic        cle,
  input  wire logic        ale,
  input  wire logic        write_strobe_n,
  input  wire logic        read_strobe_n,
  input  wire logic        wp_n,
  input  wire logic        lock_autoread_select,
  input  wire logic [15:0] io_bus,
  output logic      [15:0] io_drive,
  output logic             ready_busy_n
);
  logic [7:0]  cmd_reg = 8'hff;
  logic [15:0] page [0:15];
  logic [15:0] out_w = 16'h0;
  logic        busy = 1'b0;
  logic        drive_ok = 1'b0;
  logic        locked;
  int          acnt, col, prog_cnt, erase_cnt, hi_err, busy_viol;
  // Pulled up; low only while busy, whatever chip select does.
  assign ready_busy_n = busy ? 1'b0 : 1'b1;
  assign locked = lock_autoread_select & ~wp_n;
  // A released port shows the inverse of the last word, never a copy.
  assign io_drive = drive_ok ? out_w : ~out_w;
  // The busy timer ignores chip select until it runs out.
  task automatic go(input int ns);
    fork
      begin
        busy = 1'b1;
        #(ns);
        busy = 1'b0;
      end
    join_none
  endtask
  always @(posedge write_strobe_n) begin
    if (ce_n === 1'b0 && cle === 1'b1) begin
      if (io_bus[15:8] !== 8'h00) hi_err++;
      if (busy && io_bus[7:0] != 8'h70 && io_bus[7:0] != 8'hff) busy_viol++;
      cmd_reg = io_bus[7:0];
      acnt = 0;
      if (cmd_reg == 8'h10 && wp_n) begin
        prog_cnt++;
        go(PROG_NS);
      end
      if (cmd_reg == 8'hd0 && wp_n) begin
        erase_cnt++;
        go(ERASE_NS);
      end
    end else if (ce_n === 1'b0 && ale === 1'b1) begin
      if (io_bus[15:8] !== 8'h00) hi_err++;
      if (acnt == 0 && cmd_reg != 8'h60) col = io_bus[3:0];
      acnt++;
      if (cmd_reg == 8'h00 && acnt == 4) go(FETCH_NS);
    end else if (ce_n === 1'b0) begin
      page[col[3:0]] = io_bus;
      col++;
    end
  end
  always @(negedge read_strobe_n) begin
    if (ce_n === 1'b0) begin
      out_w = page[col[3:0]];
      col++;
      #(ACC_NS);
      drive_ok = ~read_strobe_n & ~ce_n;
    end
  end
  always @(posedge read_strobe_n or posedge ce_n) drive_ok = 1'b0;
endmodule

// ---- verif/nfpbc_host_tb.sv ----
// Register-level test of the host controller against the flash model.
`timescale 1ns/1ps
module nfpbc_host_tb;
  import nfpbc_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        ce_n, cle, ale, ws_n, rs_n, wp_n, lck, oe, rb_n;
  logic [15:0] io_out, io_drv, io_lvl;
  logic [31:0] d;
  logic [15:0] pat [0:3];
  logic        saw;
  int          errors = 0;
  int          tests_run = 0;
  // The wire carries the host's word while it drives, else the flash's.
  assign io_lvl = oe ? io_out : io_drv;
  always #5 clk = ~clk;
  nfpbc_host nfpbc_host_inst (.CLK(clk), .RST(rst), .AWADDR(awaddr),
    .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf),
    .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
    .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
    .RREADY(rready), .CE_N(ce_n), .CLE(cle), .ALE(ale),
    .WRITE_STROBE_N(ws_n), .READ_STROBE_N(rs_n), .WP_N(wp_n),
    .LOCK_AUTOREAD_SELECT(lck), .IO_IN(io_lvl), .IO_OUT(io_out),
    .IO_OE(oe), .READY_BUSY_N(rb_n));
  nfpbc_flash_model fm (.ce_n(ce_n), .cle(cle), .ale(ale),
    .write_strobe_n(ws_n), .read_strobe_n(rs_n), .wp_n(wp_n),
    .lock_autoread_select(lck), .io_bus(io_lvl), .io_drive(io_drv),
    .ready_busy_n(rb_n));
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge clk); while (awready !== 1'b1 && ++n < 3000);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    do @(posedge clk); while (bvalid !== 1'b1 && ++n < 3000);
    bready <= 1'b0;
    if (n >= 3000) errors++;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er, input logic cmp);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1 && ++n < 3000);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk); while (rvalid !== 1'b1 && ++n < 3000);
    rready <= 1'b0;
    if (n >= 3000) errors++;
    d = rdata;
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    if (cmp) chk("rdata", e, d);
  endtask
  task automatic op(input logic [1:0] k, input logic [15:0] v);
    wr(ADDR_OP, {14'h0, k, v}, RESP_OKAY);
  endtask
  // Polls status until idle, noting whether busy was ever seen.
  task automatic idle();
    saw = 1'b0;
    for (int i = 0; i < 600; i++) begin
      rd(ADDR_STATUS, 32'h0, RESP_OKAY, 1'b0);
      if (d[1] === 1'b0) saw = 1'b1;
      if (d[2:0] === 3'b110) break;
    end
    chk("idle", 32'h6, {29'h0, d[2:0]});
  endtask
  task automatic wrap_up();
    if (errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #1000000;
    errors++;
    wrap_up();
  end
  initial begin
    for (int i = 0; i < 4; i++) pat[i] = 16'ha5c3 ^ (16'h1111 * i);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    chk("ce_n", 32'h1, {31'h0, ce_n});
    chk("wp_n", 32'h0, {31'h0, wp_n});
    rd(ADDR_CTRL, 32'h0, RESP_OKAY, 1'b1);
    rd(ADDR_STATUS, 32'he, RESP_OKAY, 1'b1);
    wr(8'h40, 32'h3, RESP_SLVERR);
    rd(8'h40, 32'h0, RESP_SLVERR, 1'b1);
    // Program attempt with write protect low must not start.
    op(KIND_CMD, 16'h0080);
    for (int i = 0; i < 4; i++) op(KIND_ADDR, 16'h0000);
    op(KIND_WDATA, 16'h1234);
    op(KIND_CMD, 16'h0010);
    idle();
    chk("prog_cnt", 32'h0, fm.prog_cnt);
    wr(ADDR_CTRL, 32'h2, RESP_OKAY);
    chk("locked", 32'h1, {31'h0, fm.locked});
    wr(ADDR_CTRL, 32'h3, RESP_OKAY);
    rd(ADDR_CTRL, 32'h3, RESP_OKAY, 1'b1);
    chk("pins", 32'h3, {30'h0, lck, wp_n});
    // Program at column 2, then a fetch queued behind the busy time.
    op(KIND_CMD, 16'h0080);
    op(KIND_ADDR, 16'h0002);
    for (int i = 0; i < 3; i++) op(KIND_ADDR, 16'h0000);
    for (int i = 0; i < 4; i++) op(KIND_WDATA, pat[i]);
    op(KIND_CMD, 16'h0010);
    op(KIND_CMD, 16'h0070);
    op(KIND_CMD, 16'h0000);
    op(KIND_ADDR, 16'h0002);
    for (int i = 0; i < 3; i++) op(KIND_ADDR, 16'h0000);
    idle();
    chk("busy_seen", 32'h1, {31'h0, saw});
    chk("prog_cnt", 32'h1, fm.prog_cnt);
    chk("page2", {16'h0, pat[0]}, {16'h0, fm.page[2]});
    for (int i = 0; i < 4; i++) begin
      op(KIND_READ, 16'h0000);
      idle();
      rd(ADDR_RDATA, {16'h0, pat[i]}, RESP_OKAY, 1'b1);
      rd(ADDR_STATUS, 32'h0, RESP_OKAY, 1'b0);
      chk("rvalid", 32'h0, {31'h0, d[4]});
    end
    // Erase with a surplus address, then fill the queue while busy.
    op(KIND_CMD, 16'h0060);
    for (int i = 0; i < 4; i++) op(KIND_ADDR, 16'h0001);
    op(KIND_CMD, 16'h00d0);
    op(KIND_CMD, 16'h00ff);
    op(KIND_CMD, 16'h0000);
    for (int i = 0; i < 8; i++) op(KIND_ADDR, 16'h0000);
    rd(ADDR_STATUS, 32'h0, RESP_OKAY, 1'b0);
    chk("full", 32'h0, {30'h0, d[3:2]});
    idle();
    chk("erase_cnt", 32'h1, fm.erase_cnt);
    chk("busy_viol", 32'h0, fm.busy_viol);
    chk("hi_err", 32'h0, fm.hi_err);
    wrap_up();
  end
endmodule
